//--- src/irq_pkg.sv
// Shared constants of the interrupt source prioritiser
package irq_pkg;
  localparam int NUM_LINES = 6;
  localparam int NUM_INT = 36;
  localparam int NUM_VEC = 64;
  // Register byte offsets
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_SENSE = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0c;
  localparam logic [7:0] OFS_PRIO_A = 8'h10;
  localparam logic [7:0] OFS_PRIO_B = 8'h14;
  localparam logic [7:0] OFS_VECTOR = 8'h18;
  // Field positions in system_control_reg
  localparam int SYS_NMI_EDGE_BIT = 2;
  localparam int SYS_SCHEME_BIT = 3;
  // Reset values
  localparam logic [7:0] SYSCTL_RST = 8'h08;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIO_A_RST = 8'h00;
  localparam logic [7:0] PRIO_B_RST = 8'h00;
  // Vector numbers
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_LINE_BASE = 6'h0c;
  // Vector number of each internal source, in input bit order
  localparam logic [5:0] INT_VEC [NUM_INT] = '{
    6'h14, 6'h15, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d, 6'h1e,
    6'h20, 6'h21, 6'h22, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29,
    6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h34, 6'h35, 6'h36,
    6'h37, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
  // Priority bit of each internal source in {priority_reg_b, priority_reg_a}
  localparam logic [3:0] INT_GRP [NUM_INT] = '{
    4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1,
    4'h0, 4'h0, 4'h0, 4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'he,
    4'he, 4'he, 4'hd, 4'hd, 4'hd, 4'hd, 4'hb, 4'hb, 4'hb,
    4'hb, 4'ha, 4'ha, 4'ha, 4'ha, 4'h9, 4'h9, 4'h9, 4'h9};
  // Priority bit of each external line in priority_reg_a
  localparam logic [2:0] LINE_GRP [NUM_LINES] = '{3'h7, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4};
endpackage : irq_pkg

//--- src/lowest_set.sv
// Finds the lowest set bit of a request vector
`timescale 1ns/100ps
`default_nettype none
module lowest_set #(
  parameter int W = 64
) (
  input wire logic [W-1:0] vec_i,
  output logic found_o,
  output logic [$clog2(W)-1:0] index_o
);
  logic [W:0] below;
  logic [W-1:0] first;

  assign below[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      assign first[g] = vec_i[g] & ~below[g];
      assign below[g+1] = below[g] | vec_i[g];
    end
  endgenerate

  always_comb
  begin
    index_o = '0;
    for (int i = 0; i < W; i++)
    begin
      if (first[i])
      begin
        index_o = index_o | ($clog2(W))'(i);
      end
    end
  end

  assign found_o = below[W];
endmodule : lowest_set
`default_nettype wire

//--- src/irq_prioritiser.sv
// Interrupt source prioritiser with Wishbone register access
// Operation
// R1: Seven external and 36 internal sources accepted
// R2: Only NMI, lines 0-2 wake standby
// R3: NMI highest, ignores both CPU masks
// R4: NMI edge polarity chosen by control bit
// R5: NMI reports vector number 7
// R6: Each line senses low level or falling edge
// R7: Per-line enables, priority bits A7..A4
// R8: Pending flags shown; software clears writing 0
// R9: Lines 0-5 use vectors 12-17
// R10: Lines sensed whatever the pin direction
// R11: Software clears direction bit, avoids pin sharing
// R12: Internal source gated by flag and enable
// R13: Internal groups on A3..A0, B7..B5 bits; the code also uses B3..B1
// R14: DMA-routed source never requests, ignores masks
// R15: Smaller vector number wins by default
// R16: Non-NMI priority raisable; default after reset
// R17: Priority bits reset low, default order
// R18: Same level ties resolved by vector order
// R19: Edge mode sets on fall, level while low
// R20: I=1, UI=0 three-level: NMI and level 1
// R21: Sense bit 1 edge, 0 level
// R22: Vector address is number times four
// R23: Ascending order within group, strobe to CPU
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module irq_prioritiser
  import irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic nmi_pin_i,
  input wire logic [NUM_LINES-1:0] line_pin_n_i,
  input wire logic [NUM_INT-1:0] periph_flag_i, // R1
  input wire logic [NUM_INT-1:0] periph_en_i,
  input wire logic [NUM_INT-1:0] periph_dma_i,
  input wire logic cpu_imask_i,
  input wire logic cpu_umask_i,
  input wire logic cpu_ack_i,
  output logic cpu_irq_o,
  output logic [5:0] vec_num_o,
  output logic [15:0] vec_addr_o,
  output logic wake_o
);
  typedef struct packed {
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic [NUM_LINES-1:0] ln_s1;
    logic [NUM_LINES-1:0] ln_s2;
    logic [NUM_LINES-1:0] ln_prev;
    logic nmi_pend;
    logic [NUM_LINES-1:0] flags;
    logic [NUM_LINES-1:0] armed;
    logic [7:0] sysctl;
    logic [7:0] sense;
    logic [7:0] enable;
    logic [7:0] pra;
    logic [7:0] prb;
    logic ack;
    logic [7:0] rdata;
    logic irq;
    logic [5:0] vec;
    logic wake;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_VEC-1:0] req_all;
  logic [NUM_VEC-1:0] req_hi;
  logic [NUM_VEC-1:0] ok_all;
  logic [NUM_VEC-1:0] ok_hi;
  logic [15:0] prio_bits;
  logic [NUM_LINES-1:0] line_req;
  logic accept_lo;
  logic accept_hi;
  logic hi_found;
  logic all_found;
  logic [5:0] hi_index;
  logic [5:0] all_index;

  // Requests into the 64-entry vector space
  always_comb
  begin
    prio_bits = {st_r.prb, st_r.pra};
    req_all = '0;
    req_hi = '0;
    line_req = st_r.flags & st_r.enable[NUM_LINES-1:0]; // R7
    for (int i = 0; i < NUM_LINES; i++)
    begin
      req_all[VEC_LINE_BASE + 6'(i)] = line_req[i]; // R9
      req_hi[VEC_LINE_BASE + 6'(i)] = line_req[i] & st_r.pra[LINE_GRP[i]]; // R7
    end
    for (int i = 0; i < NUM_INT; i++)
    begin
      // Peripheral gating; DMA-routed sources never reach the controller
      req_all[INT_VEC[i]] = periph_flag_i[i] & periph_en_i[i] & ~periph_dma_i[i]; // R12 R14
      req_hi[INT_VEC[i]] = req_all[INT_VEC[i]] & prio_bits[INT_GRP[i]]; // R13 R16
    end
  end

  // CPU mask decode for the two schemes
  always_comb
  begin
    accept_lo = ~cpu_imask_i;
    accept_hi = ~cpu_imask_i | (~st_r.sysctl[SYS_SCHEME_BIT] & ~cpu_umask_i); // R20
    ok_all = accept_lo ? (req_all | req_hi) : req_hi;
    ok_hi = accept_hi ? req_hi : '0;
    if (!accept_hi)
    begin
      ok_all = '0;
    end
  end

  // Level 1 first, then default order; lowest vector wins in each
  lowest_set #(.W(NUM_VEC)) u_pick_hi (
    .vec_i(ok_hi),
    .found_o(hi_found),
    .index_o(hi_index)
  ); // R15 R18 R23

  lowest_set #(.W(NUM_VEC)) u_pick_all (
    .vec_i(ok_all),
    .found_o(all_found),
    .index_o(all_index)
  ); // R15 R18 R23

  always_comb
  begin
    logic nmi_edge;
    logic wr;
    logic rd;
    logic [NUM_LINES-1:0] set_f;
    logic [NUM_LINES-1:0] clr_f;
    nmi_edge = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    set_f = '0;
    clr_f = '0;
    st_nxt = st_r;
    // Pin synchronisers; pins read regardless of port direction
    st_nxt.nmi_s1 = nmi_pin_i;
    st_nxt.nmi_s2 = st_r.nmi_s1;
    st_nxt.nmi_prev = st_r.nmi_s2;
    st_nxt.ln_s1 = line_pin_n_i; // R10
    st_nxt.ln_s2 = st_r.ln_s1;
    st_nxt.ln_prev = st_r.ln_s2;
    // NMI edge of selected polarity
    if (st_r.sysctl[SYS_NMI_EDGE_BIT])
    begin
      nmi_edge = st_r.nmi_s2 & ~st_r.nmi_prev; // R4
    end
    else
    begin
      nmi_edge = ~st_r.nmi_s2 & st_r.nmi_prev; // R4
    end
    // Wishbone slave: ack one cycle after request, write at ack edge
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    rd = st_nxt.ack & ~wb_we_i;
    wr = wb_cyc_i & wb_stb_i & st_r.ack & wb_we_i & wb_sel_i[0];
    st_nxt.rdata = '0;
    if (rd)
    begin
      case (wb_adr_i)
        OFS_SYSCTL: st_nxt.rdata = st_r.sysctl;
        OFS_SENSE: st_nxt.rdata = st_r.sense;
        OFS_ENABLE: st_nxt.rdata = st_r.enable;
        OFS_PENDING:
        begin
          st_nxt.rdata = {2'b00, st_r.flags}; // R8
          st_nxt.armed = st_r.armed | st_r.flags;
        end
        OFS_PRIO_A: st_nxt.rdata = st_r.pra;
        OFS_PRIO_B: st_nxt.rdata = st_r.prb;
        OFS_VECTOR: st_nxt.rdata = {st_r.irq, 1'b0, st_r.vec};
        default: st_nxt.rdata = '0;
      endcase
    end
    if (wr)
    begin
      case (wb_adr_i)
        OFS_SYSCTL: st_nxt.sysctl = wb_dat_i[7:0];
        OFS_SENSE: st_nxt.sense = wb_dat_i[7:0];
        OFS_ENABLE: st_nxt.enable = wb_dat_i[7:0];
        OFS_PENDING:
        begin
          clr_f = st_r.armed & ~wb_dat_i[NUM_LINES-1:0]; // R8
          st_nxt.armed = st_r.armed & wb_dat_i[NUM_LINES-1:0];
        end
        OFS_PRIO_A: st_nxt.pra = wb_dat_i[7:0];
        OFS_PRIO_B: st_nxt.prb = wb_dat_i[7:0];
        default: st_nxt.pra = st_r.pra;
      endcase
    end
    // Line flags: set on low level or falling edge, cleared by acceptance
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (st_r.sense[i])
      begin
        set_f[i] = st_r.ln_prev[i] & ~st_r.ln_s2[i]; // R19 R21
      end
      else
      begin
        set_f[i] = ~st_r.ln_s2[i]; // R6 R19 R21
      end
      if (cpu_ack_i && st_r.irq && st_r.vec == VEC_LINE_BASE + 6'(i)
          && (st_r.sense[i] || st_r.ln_s2[i]))
      begin
        clr_f[i] = 1'b1;
      end
    end
    // Set wins over clear
    st_nxt.flags = (st_r.flags & ~clr_f) | set_f; // R8
    // Software clear needs a fresh read first
    st_nxt.armed = st_nxt.armed & st_r.flags & ~clr_f; // R8
    st_nxt.nmi_pend = (st_r.nmi_pend & ~(cpu_ack_i & st_r.irq & (st_r.vec == VEC_NMI)))
                      | nmi_edge;
    // Selection; the request drops for one cycle after each acceptance
    st_nxt.irq = 1'b0;
    if (st_r.nmi_pend)
    begin
      st_nxt.vec = VEC_NMI; // R3 R5
      st_nxt.irq = ~cpu_ack_i; // R3
    end
    else if (hi_found)
    begin
      st_nxt.vec = hi_index; // R16 R18
      st_nxt.irq = ~cpu_ack_i;
    end
    else if (all_found)
    begin
      st_nxt.vec = all_index; // R15 R17
      st_nxt.irq = ~cpu_ack_i;
    end
    st_nxt.wake = st_r.nmi_pend | (|line_req[2:0]); // R2
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.nmi_s1 <= 1'b1;
      st_r.nmi_s2 <= 1'b1;
      st_r.nmi_prev <= 1'b1;
      st_r.ln_s1 <= '1;
      st_r.ln_s2 <= '1;
      st_r.ln_prev <= '1;
      st_r.sysctl <= SYSCTL_RST;
      st_r.sense <= SENSE_RST;
      st_r.enable <= ENABLE_RST;
      st_r.pra <= PRIO_A_RST; // R17
      st_r.prb <= PRIO_B_RST; // R17
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {24'h00_0000, st_r.rdata};
  assign cpu_irq_o = st_r.irq; // R23
  assign vec_num_o = st_r.vec;
  assign vec_addr_o = {8'h00, st_r.vec, 2'b00}; // R22
  assign wake_o = st_r.wake;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_nmi_vector_first: assert property ( // R5
    st_r.nmi_pend && !cpu_ack_i |=> cpu_irq_o && vec_num_o == 6'h07)
    else $error("pending NMI not presented as vector 7");

  a_nmi_ignores_mask: assert property ( // R3
    st_r.nmi_pend && cpu_imask_i && cpu_umask_i && !cpu_ack_i |=> cpu_irq_o)
    else $error("NMI masked by CPU mask bits");

  a_single_mask_block: assert property ( // R20
    !st_r.nmi_pend && cpu_imask_i && st_r.sysctl[SYS_SCHEME_BIT] |=> !cpu_irq_o)
    else $error("maskable request passed with I set");

  a_three_level_mask: assert property ( // R20
    cpu_irq_o && vec_num_o != 6'h07 && $past(cpu_imask_i)
      |-> !$past(cpu_umask_i) && !$past(st_r.sysctl[SYS_SCHEME_BIT])
          && ($past(req_hi) & (64'h0000_0000_0000_0001 << vec_num_o)) != '0)
    else $error("request passed a three-level mask");

  a_line0_vector_map: assert property ( // R9
    cpu_irq_o && vec_num_o == 6'h0c |-> $past(line_req[0]) && vec_addr_o == 16'h0030)
    else $error("vector 12 without line 0 request");

  a_edge_sets_flag: assert property ( // R19
    st_r.sense[1] && st_r.ln_prev[1] && !st_r.ln_s2[1] |=> st_r.flags[1])
    else $error("falling edge did not set flag");

  a_level_sets_flag: assert property ( // R6
    !st_r.sense[4] && !st_r.ln_s2[4] ##1 !st_r.sense[4] |-> st_r.flags[4])
    else $error("low level did not set flag");

  a_dma_source_silent: assert property ( // R14
    cpu_irq_o && vec_num_o == 6'h18 |-> !$past(periph_dma_i[3]))
    else $error("DMA-routed source raised a request");

  a_default_order: assert property ( // R15
    cpu_irq_o && $past(ok_hi) == '0 && vec_num_o != 6'h07
      |-> ($past(ok_all) & ((64'h0000_0000_0000_0001 << vec_num_o) - 64'h0000_0000_0000_0001))
          == '0)
    else $error("lower vector number was passed over");

  a_wake_sources: assert property ( // R2
    !st_r.nmi_pend && line_req[2:0] == '0 |=> !wake_o)
    else $error("wake raised by a non-waking source");

  a_no_reserved_vec: assert property ( // R22
    cpu_irq_o |-> !(vec_num_o inside {[6'h00:6'h06], [6'h08:6'h0b], 6'h12, 6'h13, 6'h16,
                                      6'h1b, 6'h1f, 6'h23, [6'h30:6'h33]}))
    else $error("reserved vector number presented");

  a_irq_drop_ack: assert property ( // R23
    cpu_irq_o && cpu_ack_i |=> !cpu_irq_o)
    else $error("request strobe held after acceptance");

  a_soft_clear_flag: assert property ( // R8
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_PENDING
      && st_r.armed[1] && !wb_dat_i[1] && st_r.ln_s2[1] |=> !st_r.flags[1])
    else $error("written zero did not clear a read flag");

  a_nmi_edge_sets: assert property ( // R4
    st_r.sysctl[SYS_NMI_EDGE_BIT] && st_r.nmi_s2 && !st_r.nmi_prev |=> st_r.nmi_pend)
    else $error("rising NMI edge not taken");

  a_periph_gating: assert property ( // R12
    cpu_irq_o && vec_num_o == 6'h14 |-> $past(periph_flag_i[0]) && $past(periph_en_i[0]))
    else $error("internal source requested without flag and enable");

endmodule : irq_prioritiser
`default_nettype wire

//--- testbench/cpu_model.sv
// CPU core acceptance and peripheral flag model
`timescale 1ns/100ps
`default_nettype none
module cpu_model
  import irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic [5:0] vec_i,
  input wire logic slow_i,
  input wire logic load_i,
  input wire logic [NUM_INT-1:0] load_val_i,
  output logic ack_o,
  output logic [NUM_INT-1:0] flag_o
);
  logic [2:0] wait_r;
  logic [1:0] hold_r;
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if (rst_i)
    begin
      wait_r <= 3'h0;
      hold_r <= 2'h0;
      flag_o <= '0;
    end
    else
    begin
      // Refractory gap keeps acks apart
      if (hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
      else if (irq_i)
      begin
        if (wait_r == (slow_i ? 3'h4 : 3'h0))
        begin
          ack_o <= 1'b1;
          hold_r <= 2'h3;
          wait_r <= 3'h0;
        end
        else
          wait_r <= wait_r + 3'h1;
      end
      if (load_i)
        flag_o <= load_val_i;
      // Serviced peripheral drops its flag
      for (int i = 0; i < NUM_INT; i++)
        if (ack_o && INT_VEC[i] == vec_i)
          flag_o[i] <= 1'b0;
    end
  end
endmodule : cpu_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the interrupt source prioritiser
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, nmi = 1;
  logic imask = 1, umask = 1, slow = 0, load = 0, ack_o, cack, irq, wake;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1, sel_req = 4'h1;
  logic [31:0] wdat = '0, rdat, seed = 32'hf5e3_57bb;
  logic [5:0] pins = 6'h3f, vec;
  logic [15:0] vaddr;
  logic [NUM_INT-1:0] en = '0, dma = '0, lval = '0, flags;
  logic [31:0] rq[$];
  logic [5:0] vq[$];
  int n_errors = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  irq_prioritiser dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack_o), .nmi_pin_i(nmi), .line_pin_n_i(pins), .periph_flag_i(flags),
    .periph_en_i(en), .periph_dma_i(dma), .cpu_imask_i(imask), .cpu_umask_i(umask),
    .cpu_ack_i(cack), .cpu_irq_o(irq), .vec_num_o(vec), .vec_addr_o(vaddr), .wake_o(wake));
  cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .vec_i(vec), .slow_i(slow),
    .load_i(load), .load_val_i(lval), .ack_o(cack), .flag_o(flags));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task chk_wake(input logic e);
    repeat (2) @(negedge clk_i);
    chk("wake", {31'h0, e}, {31'h0, wake});
  endtask : chk_wake
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // Watcher compares results against the oldest note
  always @(posedge clk_i)
  begin
    if (!rst_i && ack_o === 1'b1 && !we && rq.size() > 0)
      chk("read data", rq.pop_front(), rdat);
    if (!rst_i && cack === 1'b1 && irq === 1'b1)
    begin
      if (vq.size() > 0)
      begin
        chk("vector address", {16'h0000, 8'h00, vq[0], 2'b00}, {16'h0000, vaddr});
        chk("vector number", {26'h0, vq.pop_front()}, {26'h0, vec});
      end
      else
      begin
        chk("unexpected vector", 32'h0000_00ff, {26'h0, vec});
      end
    end
  end
  task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= sel_req;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    wb(a, 0, 8'h00);
  endtask : rd
  task drain(input string nm);
    repeat (300) if (vq.size() != 0) @(posedge clk_i);
    chk("queue left", 0, vq.size());
    $display("test %s done", nm);
  endtask : drain
  task pulse(input logic [5:0] p, input int n);
    @(posedge clk_i);
    pins <= p;
    repeat (n) @(posedge clk_i);
    pins <= 6'h3f;
    repeat (5) @(posedge clk_i);
  endtask : pulse
  logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 8; i++)
      rd(ofs[i], i == 0 ? SYSCTL_RST : 8'h00);
    $display("test reset done");
    vq.push_back(VEC_NMI);
    nmi <= 0;
    drain("nmi falling");
    wb(OFS_SYSCTL, 1, 8'h0c);
    vq.push_back(VEC_NMI);
    nmi <= 1;
    drain("nmi rising");
    wb(OFS_SENSE, 1, 8'h3f);
    wb(OFS_ENABLE, 1, 8'h3f);
    sel_req = 4'h0;
    wb(OFS_ENABLE, 1, 8'h00);
    sel_req = 4'h1;
    rd(OFS_ENABLE, 8'h3f);
    pulse(6'h35, 4);
    rd(OFS_PENDING, 8'h0a);
    chk_wake(1'b1);
    wb(OFS_PENDING, 1, 8'h08);
    rd(OFS_PENDING, 8'h08);
    chk_wake(1'b0);
    vq.push_back(6'd15);
    imask <= 0;
    drain("edge lines");
    slow <= 1;
    imask <= 1;
    umask <= 0;
    wb(OFS_SYSCTL, 1, 8'h00);
    wb(OFS_SENSE, 1, 8'h00);
    wb(OFS_PRIO_A, 1, 8'h20);
    vq.push_back(6'd15);
    pulse(6'h26, 2);
    drain("three level");
    rd(OFS_PENDING, 8'h11);
    chk_wake(1'b1);
    vq.push_back(6'd12);
    vq.push_back(6'd16);
    imask <= 0;
    drain("level zero");
    chk_wake(1'b0);
    slow <= 0;
    seed = lfsr_next(seed);
    en <= {seed[3:0], seed};
    lval <= {seed[9:6], ~seed};
    seed = lfsr_next(seed);
    // Only timer, serial and A/D sources may be routed to DMA
    dma <= {seed[1:0], seed[31:30], seed[31:0] & 32'hff00_0ffc};
    @(posedge clk_i);
    for (int i = 0; i < NUM_INT; i++)
      if (lval[i] && en[i] && !dma[i])
        vq.push_back(INT_VEC[i]);
    load <= 1;
    @(posedge clk_i);
    load <= 0;
    drain("internal");
    close_out;
  end
  initial
  begin
    #300us;
    n_errors++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
